// *** rtl/splr_defs.svh ***
// Constants for the set-point limiter and ramp block.
// Assumes inclusion by bare name from rtl files.
`ifndef SPLR_DEFS_SVH
`define SPLR_DEFS_SVH
`define SPLR_SP_W          16
`define SPLR_CLK_HZ        40000000
`define SPLR_RATE_OFF      16'h0000
`define SPLR_UNIT_SEC      1'b0
`define SPLR_UNIT_MIN      1'b1
`define SPLR_SEC_TIME      1
`define SPLR_SEC_CYCLES    (`SPLR_SEC_TIME * `SPLR_CLK_HZ)
`define SPLR_MIN_CYCLES    (32'd60 * `SPLR_SEC_CYCLES)
`define SPLR_ALARM_RAMP    1'b0
`define SPLR_ALARM_TARGET  1'b1
`define SPLR_RST_SP        16'h0000
`define SPLR_RST_UPPER     16'h7fff
`define SPLR_RST_LOWER     16'h8000
`endif

// *** rtl/splr_pkg.sv ***
// Types shared by the set-point limiter and ramp block.
// Assumes splr_defs.svh is on the include path.
`include "splr_defs.svh"
package splr_pkg;
  typedef logic signed [`SPLR_SP_W-1:0] splr_sp_t;
  typedef struct packed {
    splr_sp_t upper;
    splr_sp_t lower;
  } splr_limits_s;
  typedef enum logic [1:0] {SPLR_IDLE, SPLR_RAMP, SPLR_HOLD} splr_state_e;
endpackage

// *** rtl/splr_top.sv ***
// Set-point limiter and rate limiter feeding the control loop and alarms.
// Assumes all inputs synchronous to REF_CLK and signed set-point codes.
// Assumes splr_pkg is compiled first and splr_defs.svh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "splr_defs.svh"
module splr_top #(
  parameter int unsigned SEC_CYCLES = `SPLR_SEC_CYCLES,
  parameter int unsigned MIN_CYCLES = `SPLR_MIN_CYCLES
) (
  input  wire  logic                   REF_CLK,
  input  wire  logic                   RST_N,
  input  wire  logic [3:0][`SPLR_SP_W-1:0] SP_BANK,
  input  wire  logic [1:0]             SP_SELECT,
  input  wire  splr_pkg::splr_limits_s LIMITS_IN,
  input  wire  logic                   LIMITS_LOAD,
  input  wire  splr_pkg::splr_limits_s RANGE_IN,
  input  wire  logic                   INPUT_CFG_CHANGE,
  input  wire  logic                   LIMITER_RESET,
  input  wire  splr_pkg::splr_sp_t     PROCESS_VALUE,
  input  wire  logic [`SPLR_SP_W-1:0]  RAMP_RATE_VALUE,
  input  wire  logic                   RAMP_TIME_UNIT,
  input  wire  logic                   RUN,
  input  wire  logic                   ERROR,
  input  wire  logic                   ALARM_SP_SELECT,
  input  wire  logic                   AT_REQUEST,
  output logic [`SPLR_SP_W-1:0]        LOOP_SP,
  output logic [`SPLR_SP_W-1:0]        ALARM_SP,
  output logic [`SPLR_SP_W-1:0]        RAMP_SP_MONITOR,
  output logic [`SPLR_SP_W-1:0]        TARGET_SP,
  output logic [`SPLR_SP_W-1:0]        SP_UPPER_LIMIT,
  output logic [`SPLR_SP_W-1:0]        SP_LOWER_LIMIT,
  output logic                         RAMP_ACTIVE,
  output logic                         AT_START
);

  function automatic splr_pkg::splr_sp_t clamp(input splr_pkg::splr_sp_t v,
                                               input splr_pkg::splr_limits_s l);
    if (v > l.upper)
      clamp = l.upper;
    else if (v < l.lower)
      clamp = l.lower;
    else
      clamp = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Limiter bounds.
  splr_pkg::splr_limits_s lim_r;
  splr_pkg::splr_limits_s lim_nxt;
  splr_pkg::splr_limits_s load_lim;
  logic                   lim_touch;

  // A loaded pair is confined to the input range so loaded limits never exceed it.
  // A pair with the upper limit below the lower one is not reordered here.
  assign load_lim  = '{upper: clamp(LIMITS_IN.upper, RANGE_IN),
                       lower: clamp(LIMITS_IN.lower, RANGE_IN)};
  assign lim_nxt   = INPUT_CFG_CHANGE ? RANGE_IN :
                     (LIMITS_LOAD ? load_lim : lim_r);
  assign lim_touch = INPUT_CFG_CHANGE | LIMITS_LOAD | LIMITER_RESET;
  // Full-range reset bounds leave the set point free until a range is loaded.

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      lim_r.upper <= `SPLR_RST_UPPER;
      lim_r.lower <= `SPLR_RST_LOWER;
    end
    else
      lim_r <= lim_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target set point: bank selection passed through the limiter.
  splr_pkg::splr_sp_t target_r;
  splr_pkg::splr_sp_t target_nxt;
  splr_pkg::splr_sp_t bank_sp;

  // An unused bank entry must still hold a sane value, as any index may be selected.
  assign bank_sp    = splr_pkg::splr_sp_t'(SP_BANK[SP_SELECT]);
  // Clamping against the next bounds snaps an outside point on any limit event.
  assign target_nxt = clamp(bank_sp, lim_nxt);

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      target_r <= `SPLR_RST_SP;
    else
      target_r <= target_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp time base and step.
  logic [31:0]        tick_cnt_r;
  logic [31:0]        tick_cnt_nxt;
  logic [31:0]        tick_len;
  logic               tick;
  logic               ramp_en;
  logic               run_d_r;
  logic               pu_r;
  logic               start_ramp;
  splr_pkg::splr_sp_t ramp_r;
  splr_pkg::splr_sp_t ramp_nxt;
  splr_pkg::splr_sp_t seed;
  logic signed [`SPLR_SP_W:0] diff;
  logic signed [`SPLR_SP_W:0] step;
  logic               at_pend_r;
  logic               at_pend_nxt;

  assign tick_len = (RAMP_TIME_UNIT == `SPLR_UNIT_MIN) ? MIN_CYCLES : SEC_CYCLES;
  // The unit is read every cycle, so changing it mid-ramp stretches or shortens the
  // step under way instead of restarting it.
  assign tick     = (tick_cnt_r >= tick_len - 32'h1);
  assign tick_cnt_nxt = (tick || !ramp_en || start_ramp) ? 32'h0 : tick_cnt_r + 32'h1;
  assign ramp_en  = (RAMP_RATE_VALUE != `SPLR_RATE_OFF) && RUN && !ERROR;
  // Only power-up or a stop-to-run change reseeds; enabling the rate alone does not.
  assign start_ramp = ramp_en && (pu_r || (RUN && !run_d_r));
  // The process value is clamped too, so the loop never sees an out-of-range point.
  assign seed     = clamp(PROCESS_VALUE, lim_nxt);
  assign diff     = {target_nxt[`SPLR_SP_W-1], target_nxt} - {ramp_r[`SPLR_SP_W-1], ramp_r};
  assign step     = {1'b0, RAMP_RATE_VALUE};

  always_comb
  begin
    ramp_nxt = ramp_r;
    // A disabled ramp tracks the target at once, so re-enabling without a stop-to-run change starts settled.
    if (!ramp_en)
      ramp_nxt = target_nxt;
    else if (start_ramp)
      ramp_nxt = seed;
    // A limit event re-clamps the ramp point; stepping resumes on the next tick.
    else if (lim_touch)
      ramp_nxt = clamp(ramp_r, lim_nxt);
    else if (tick)
    begin
      // The last step lands exactly on the target rather than overshooting it.
      if (diff > step)
        ramp_nxt = splr_pkg::splr_sp_t'(ramp_r + RAMP_RATE_VALUE);
      else if (diff < -step)
        ramp_nxt = splr_pkg::splr_sp_t'(ramp_r - RAMP_RATE_VALUE);
      else
        ramp_nxt = target_nxt;
    end
  end

  // The counter restarts with every ramp start, so the first step after a start comes a full unit later.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      tick_cnt_r <= 32'h0;
    else
      tick_cnt_r <= tick_cnt_nxt;
  end

  // The power-up flag lives for the first edge after reset only; it stands in for a
  // stop-to-run change when the block comes up already running.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      run_d_r <= 1'b0;
      pu_r    <= 1'b1;
    end
    else
    begin
      run_d_r <= RUN;
      pu_r    <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      ramp_r <= `SPLR_RST_SP;
    else
      ramp_r <= ramp_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-tune hand-off.
  // A request seen during the ramp is held; the hold clears in the cycle that shows
  // AT_START, since that start answers every request made up to then.
  assign at_pend_nxt = (at_pend_r || AT_REQUEST) && !AT_START;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      at_pend_r <= 1'b0;
    else
      at_pend_r <= at_pend_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // RAMP_ACTIVE and AT_START are decoded from registers and inputs and settle within the cycle.
  assign RAMP_ACTIVE     = ramp_en && (ramp_r != target_r);
  assign LOOP_SP         = ramp_r;
  assign RAMP_SP_MONITOR = ramp_r;
  assign TARGET_SP       = target_r;
  // Alarms always see a clamped register, never a raw bank entry.
  assign ALARM_SP        = (ALARM_SP_SELECT == `SPLR_ALARM_TARGET) ? target_r : ramp_r;
  assign SP_UPPER_LIMIT  = lim_r.upper;
  assign SP_LOWER_LIMIT  = lim_r.lower;
  assign AT_START        = (at_pend_r || AT_REQUEST) && !RAMP_ACTIVE;

endmodule
`default_nettype wire

// *** verification/splr_chk.sv ***
// Assertion checker for splr_top: limits, ramp steps and set-point outputs.
// Assumes one clock domain; bound to every splr_top instance below.
`timescale 1ns/1ps
`default_nettype none
module splr_chk #(
  parameter int unsigned SEC_CYCLES = 4,
  parameter int unsigned MIN_CYCLES = 8
) (
  input wire logic                   REF_CLK,
  input wire logic                   RST_N,
  input wire splr_pkg::splr_limits_s RANGE_IN,
  input wire logic                   INPUT_CFG_CHANGE,
  input wire logic [15:0]            RAMP_RATE_VALUE,
  input wire logic                   RUN,
  input wire logic                   ERROR,
  input wire logic                   ALARM_SP_SELECT,
  input wire logic [15:0]            LOOP_SP,
  input wire logic [15:0]            ALARM_SP,
  input wire logic [15:0]            RAMP_SP_MONITOR,
  input wire logic [15:0]            TARGET_SP,
  input wire logic [15:0]            SP_UPPER_LIMIT,
  input wire logic [15:0]            SP_LOWER_LIMIT,
  input wire logic                   RAMP_ACTIVE,
  input wire logic                   AT_START
);
  wire signed [15:0] tg = TARGET_SP;
  wire signed [15:0] lp = LOOP_SP;
  wire signed [16:0] rt = {1'b0, RAMP_RATE_VALUE};
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_settled; !RAMP_ACTIVE ##1 (!RAMP_ACTIVE && $stable(TARGET_SP)); endsequence
  // A limit change may move the ramp point by more than one step, so it is left out.
  sequence s_steady;
    RAMP_ACTIVE ##1 (RAMP_ACTIVE && $stable(SP_UPPER_LIMIT) && $stable(SP_LOWER_LIMIT));
  endsequence
  property p_lim; tg <= $signed(SP_UPPER_LIMIT) && tg >= $signed(SP_LOWER_LIMIT); endproperty
  a_lim: assert property (p_lim) else $error("target outside limits");
  property p_cfg; INPUT_CFG_CHANGE |=> {SP_UPPER_LIMIT, SP_LOWER_LIMIT} == $past(RANGE_IN); endproperty
  a_cfg: assert property (p_cfg) else $error("limits not reloaded");
  property p_off; (RAMP_RATE_VALUE == 16'h0000 || !RUN || ERROR) |->
    !RAMP_ACTIVE ##1 (LOOP_SP == TARGET_SP);
  endproperty
  a_off: assert property (p_off) else $error("ramp while disabled");
  property p_mon; RAMP_SP_MONITOR == LOOP_SP; endproperty
  a_mon: assert property (p_mon) else $error("monitor differs");
  property p_at; AT_START |-> !RAMP_ACTIVE; endproperty
  a_at: assert property (p_at) else $error("tune during ramp");
  property p_alm; ALARM_SP == (ALARM_SP_SELECT ? TARGET_SP : LOOP_SP); endproperty
  a_alm: assert property (p_alm) else $error("alarm point wrong");
  property p_step; s_steady |-> lp - $past(lp) <= rt && $past(lp) - lp <= rt;
  endproperty
  a_step: assert property (p_step) else $error("ramp step too big");
  property p_hold; s_settled |-> LOOP_SP == TARGET_SP; endproperty
  a_hold: assert property (p_hold) else $error("ramp not on target");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind splr_top splr_chk #(.SEC_CYCLES(SEC_CYCLES), .MIN_CYCLES(MIN_CYCLES)) u_splr_chk (
  .REF_CLK, .RST_N, .RANGE_IN, .INPUT_CFG_CHANGE, .RAMP_RATE_VALUE, .RUN, .ERROR,
  .ALARM_SP_SELECT, .LOOP_SP, .ALARM_SP, .RAMP_SP_MONITOR, .TARGET_SP, .SP_UPPER_LIMIT,
  .SP_LOWER_LIMIT, .RAMP_ACTIVE, .AT_START);
`default_nettype wire

// *** verification/splr_plant.sv ***
// Far-side model: plant process value and an upper alarm comparator.
// Assumes the bench sets the wanted process value between edges.
`timescale 1ns/1ps
`default_nettype none
module splr_plant (
  input  wire logic               clk,
  input  wire splr_pkg::splr_sp_t pv_req,
  input  wire logic [15:0]        alarm_sp,
  output var splr_pkg::splr_sp_t  pv,
  output logic                    alarm_hi
);
  // The plant moves on the falling edge so the block samples a settled value.
  always_ff @(negedge clk) pv <= pv_req;
  assign alarm_hi = pv > $signed(alarm_sp);
endmodule
`default_nettype wire

// *** verification/splr_top_tb_top.sv ***
// Self-checking bench for splr_top with the plant model on the far side.
// Assumes short tick parameters, so one ramp step takes a few cycles.
`timescale 1ns/1ps
`default_nettype none
module splr_top_tb_top;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [3:0][15:0]       bank = '0;
  logic [1:0]             sel = 2'h0;
  splr_pkg::splr_limits_s lim = '0;
  splr_pkg::splr_limits_s rng = '0;
  splr_pkg::splr_sp_t     pv_req = '0;
  splr_pkg::splr_sp_t     pv;
  logic [15:0]            rate = '0;
  logic                   ld = 1'b0, cfg = 1'b0, lres = 1'b0, unit = 1'b0;
  logic                   run = 1'b0, err = 1'b0, asel = 1'b0, atr = 1'b0;
  logic [15:0]            loop_sp, alarm_sp, mon, tgt, up, lo;
  logic                   act, ats, alarm_hi;
  int                     failures = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  splr_plant u_splr_plant (.clk(clk), .pv_req(pv_req), .alarm_sp(alarm_sp), .pv(pv),
    .alarm_hi(alarm_hi));
  splr_top #(.SEC_CYCLES(4), .MIN_CYCLES(8)) u_splr_top (.REF_CLK(clk), .RST_N(rst_n),
    .SP_BANK(bank), .SP_SELECT(sel), .LIMITS_IN(lim), .LIMITS_LOAD(ld), .RANGE_IN(rng),
    .INPUT_CFG_CHANGE(cfg), .LIMITER_RESET(lres), .PROCESS_VALUE(pv), .RAMP_RATE_VALUE(rate),
    .RAMP_TIME_UNIT(unit), .RUN(run), .ERROR(err), .ALARM_SP_SELECT(asel), .AT_REQUEST(atr),
    .LOOP_SP(loop_sp), .ALARM_SP(alarm_sp), .RAMP_SP_MONITOR(mon), .TARGET_SP(tgt),
    .SP_UPPER_LIMIT(up), .SP_LOWER_LIMIT(lo), .RAMP_ACTIVE(act), .AT_START(ats));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (++cyc == 400)
    begin
      failures++;
      tally_and_finish();
    end
  initial
  begin
    tick(10);
    rst_n = 1'b1;
    tick(1);
    chk("upper", up, 16'h7fff);
    chk("lower", lo, 16'h8000);
    rng = '{16'h0064, 16'hff9c};
    pv_req = 16'sh0005;
    bank[0] = 16'h00c8;
    cfg = 1'b1;
    tick(1);
    cfg = 1'b0;
    tick(1);
    chk("upper range", up, 16'h0064);
    chk("lower range", lo, 16'hff9c);
    chk("target", tgt, 16'h0064);
    chk("loop", loop_sp, 16'h0064);
    $display("test limits done");
    bank[0] = 16'h0032;
    rate = 16'h000a;
    run = 1'b1;
    tick(1);
    chk("start", loop_sp, 16'h0005);
    chk("monitor", mon, 16'h0005);
    chk("alarm ramp", alarm_sp, 16'h0005);
    chk("active", act, 16'h0001);
    atr = 1'b1;
    tick(1);
    atr = 1'b0;
    chk("tune early", ats, 16'h0000);
    for (int i = 0; i < 60 && act !== 1'b0; i++)
      tick(1);
    chk("tune late", ats, 16'h0001);
    chk("reached", loop_sp, 16'h0032);
    $display("test rise done");
    unit = 1'b1;
    bank[1] = 16'hffce;
    sel = 2'h1;
    asel = 1'b1;
    tick(1);
    chk("bank ramp", act, 16'h0001);
    chk("alarm", alarm_sp, 16'hffce);
    tick(9);
    chk("falling", 16'($signed(loop_sp) < 16'sh0032), 16'h0001);
    chk("fall step", loop_sp, 16'h0028);
    err = 1'b1;
    tick(1);
    chk("error", loop_sp, 16'hffce);
    err = 1'b0;
    lim = '{16'h0028, 16'hffd8};
    ld = 1'b1;
    lres = 1'b1;
    tick(1);
    ld = 1'b0;
    lres = 1'b0;
    tick(1);
    chk("clamp", tgt, 16'hffd8);
    chk("ramp clamp", loop_sp, 16'hffd8);
    chk("alarm hi", alarm_hi, 16'h0001);
    $display("test fall done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
